// File: logic/tpwm_consts.vh
// Constants shared by the two-channel PWM timer block.
`ifndef TPWM_CONSTS_VH
`define TPWM_CONSTS_VH
`define TPWM_CNT_W 16
`define TPWM_MOD_RESET 16'hFFFF
`define TPWM_CMP_RESET 16'h0000
`define TPWM_PS_W 3
`define TPWM_PS_UNUSED 3'h7
`define TPWM_MODE_UNBUF 2'h1
`define TPWM_MODE_BUF 2'h2
`define TPWM_MS_B 1
`define TPWM_MS_A 0
`define TPWM_ACT_CLEAR 2'h2
`define TPWM_ACT_SET 2'h3
`define TPWM_ACT_B 1
`define TPWM_PRE_W 6
`endif

// File: logic/tpwm_timer_pwm_channels.v
// Two-channel 16-bit timer with modulo counter, prescaler, PWM and buffered pairing.
`timescale 1ns/1ps
`include "tpwm_consts.vh"

// Notes on behaviour
// (R1) Toggle-on-wrap toggles the channel pin each time the counter reaches modulo.
// (R2) Pulse width is the time from counter wrap to the compare match.
// (R3) Divide-by-one with modulo 255 gives a 256 bus clock period.
// (R4) Compare value 128 with a 256-count period gives 50 percent duty.
// (R5) Software writes shorter widths in compare handler, longer in wrap handler.
// (R6) Software must not set toggle-on-compare for PWM channels.
// (R7) Channel 0 link bit pairs channels into buffered PWM, channel 0 compare first.
// (R8) A channel 1 compare write takes over next period; last written pair governs.
// (R9) While linked, channel 1 control is ignored and its pin released.
// (R10) Software writes new widths only to the inactive compare pair.
// (R11) Software halts and clears counter, writes values, configures, then releases halt.
// (R12) Mode code 0:1 is unbuffered compare, 1:0 buffered compare.
// (R13) Action code 1:0 clears pin on compare, 1:1 sets it.
// (R14) Channel 0 mode bit B wins over mode bit A.
// (R15) Without toggle-on-wrap the pin never toggles, giving 0 percent duty.
// (R16) Full duty bit with toggle-on-wrap gives constant 100 percent duty.
// (R17) Wrap flag sets on reaching modulo; request only when its enable is set.
// (R18) Channel flag sets on compare match; request only when channel enable is set.
// (R19) In wait the timer runs; enabled requests drive the wake output.
// (R20) In stop the timer freezes, holding counter and registers, then resumes.
// (R21) During break the counter and prescaler halt.
// (R22) In break, flags clear only with clear enable; pending clear finishes afterwards.
// (R23) After reaching modulo the counter restarts from zero at next timer clock.
// (R24) Prescale codes 000 to 110 divide by 1 to 64; 111 is unused.
// (R25) Counter clear pulse resets counter and prescaler only and reads as zero.
module tpwm_timer_pwm_channels
(
    input wire clk_sys,
    input wire sys_rst,
    input wire counter_halt_bit,
    input wire counter_clear,
    input wire [2:0] prescale_select,
    input wire [15:0] modulo_value,
    input wire modulo_write,
    input wire [15:0] compare0_value,
    input wire compare0_write,
    input wire [15:0] compare1_value,
    input wire compare1_write,
    input wire [1:0] ch0_mode,
    input wire [1:0] ch1_mode,
    input wire [1:0] ch0_output_action,
    input wire [1:0] ch1_output_action,
    input wire ch0_toggle_on_wrap_bit,
    input wire ch1_toggle_on_wrap_bit,
    input wire ch0_full_duty_bit,
    input wire ch1_full_duty_bit,
    input wire wrap_irq_enable,
    input wire ch0_irq_enable,
    input wire ch1_irq_enable,
    input wire wrap_flag_read,
    input wire wrap_flag_clear,
    input wire ch0_flag_read,
    input wire ch0_flag_clear,
    input wire ch1_flag_read,
    input wire ch1_flag_clear,
    input wire stop_mode,
    input wire break_state,
    input wire break_flag_clear_enable,
    output reg [15:0] counter,
    output reg channel0_pin,
    output reg channel1_pin,
    output reg channel1_pin_released,
    output reg active_pair,
    output reg wrap_flag,
    output reg ch0_event_flag,
    output reg ch1_event_flag,
    output reg timer_irq
);

    reg [5:0] prescaler;
    reg [15:0] modulo;
    reg [15:0] compare0;
    reg [15:0] compare1;
    reg pendingSwap;
    reg wrapArmed;
    reg ch0Armed;
    reg ch1Armed;
    reg [15:0] next_counter;
    reg tick;
    wire running;
    wire linked;
    wire wrap;
    wire [15:0] ch0Compare;
    wire match0;
    wire match1;
    wire ch1Active;
    wire wrapClearOk;
    wire ch0ClearOk;
    wire ch1ClearOk;
    wire clearAllowed;
    wire stepping;

    // Stop, break and the halt bit all freeze the counting path.
    assign running = ~counter_halt_bit & ~stop_mode & ~break_state; // R20 R21
    // Bit B is checked alone, so it overrides bit A whatever A holds.
    assign linked = ch0_mode[`TPWM_MS_B]; // R7 R12 R14
    assign ch1Active = ~linked & (ch1_mode == `TPWM_MODE_UNBUF); // R9 R12
    assign wrap = tick & (counter == modulo); // R17 R23
    assign ch0Compare = (linked & active_pair) ? compare1 : compare0; // R8

    // Matches look at the value the counter is about to take, so a compare of N
    // keeps the pulse for N timer clocks after the wrap, and a compare of zero
    // meets the wrap itself. A clear in the same edge cancels the match, since
    // the counter never takes the value that was compared.
    assign stepping = tick & ~counter_clear;
    assign match0 = stepping & (next_counter == ch0Compare); // R2 R4
    assign match1 = stepping & (next_counter == compare1) & ch1Active; // R9

    // Prescaler tap select; the unused code yields no timer clock.
    // Each tap fires once per divide period, on the all-ones phase of the prescaler.
    always @*
    begin
        case (prescale_select) // R24
            3'h0: tick = running;
            3'h1: tick = running & (prescaler[0] == 1'b1);
            3'h2: tick = running & (prescaler[1:0] == 2'h3);
            3'h3: tick = running & (prescaler[2:0] == 3'h7);
            3'h4: tick = running & (prescaler[3:0] == 4'hF);
            3'h5: tick = running & (prescaler[4:0] == 5'h1F);
            3'h6: tick = running & (prescaler == 6'h3F);
            default: tick = 1'b0;
        endcase
    end

    // Next counter value: restart from zero after the modulo is reached.
    always @*
    begin
        if (wrap)
        begin
            next_counter = 16'h0000; // R23 R3
        end
        else if (tick)
        begin
            next_counter = counter + 16'h0001;
        end
        else
        begin
            next_counter = counter;
        end
    end

    // Counter, prescaler and configuration storage.
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            counter <= 16'h0000;
            prescaler <= 6'h00;
            modulo <= `TPWM_MOD_RESET;
            compare0 <= `TPWM_CMP_RESET;
            compare1 <= `TPWM_CMP_RESET;
        end
        else
        begin
            if (counter_clear)
            begin
                counter <= 16'h0000; // R25
                prescaler <= 6'h00; // R25
            end
            else
            begin
                counter <= next_counter;
                if (running)
                begin
                    prescaler <= prescaler + 6'h01;
                end
            end
            if (modulo_write)
            begin
                modulo <= modulo_value;
            end
            if (compare0_write)
            begin
                compare0 <= compare0_value;
            end
            if (compare1_write)
            begin
                compare1 <= compare1_value;
            end
        end
    end

    // Buffered pair tracking: the last written pair takes over at the next wrap.
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            active_pair <= 1'b0;
            pendingSwap <= 1'b0;
        end
        else if (!linked)
        begin
            active_pair <= 1'b0; // R7
            pendingSwap <= 1'b0;
        end
        else
        begin
            if (wrap)
            begin
                active_pair <= pendingSwap; // R8
            end
            if (compare1_write)
            begin
                pendingSwap <= 1'b1; // R8
            end
            else if (compare0_write)
            begin
                pendingSwap <= 1'b0; // R8
            end
        end
    end

    // Pin drive. Compare is checked before the wrap toggle, so a compare of zero
    // meets the wrap in the same edge and holds the pin at its compare level.
    // Channel 1 is left alone while linked, its pin then belongs to port logic.
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            channel0_pin <= 1'b0;
            channel1_pin <= 1'b0;
            channel1_pin_released <= 1'b0;
        end
        else
        begin
            channel1_pin_released <= linked; // R9
            if (ch0_full_duty_bit & ch0_toggle_on_wrap_bit)
            begin
                channel0_pin <= ~ch0_output_action[0]; // R16
            end
            else if (match0 & ch0_output_action[`TPWM_ACT_B])
            begin
                channel0_pin <= ch0_output_action[0]; // R13 R2 R4
            end
            else if (wrap & ch0_toggle_on_wrap_bit)
            begin
                channel0_pin <= ~channel0_pin; // R1 R15
            end
            if (ch1Active & ch1_full_duty_bit & ch1_toggle_on_wrap_bit)
            begin
                channel1_pin <= ~ch1_output_action[0]; // R16
            end
            else if (match1 & ch1_output_action[`TPWM_ACT_B])
            begin
                channel1_pin <= ch1_output_action[0]; // R13
            end
            else if (ch1Active & wrap & ch1_toggle_on_wrap_bit)
            begin
                channel1_pin <= ~channel1_pin; // R1 R15
            end
        end
    end

    // Two-step clears: a read of a set flag arms, a clear strobe finishes.
    // In break without clear enable the strobe is ignored but the arming holds.
    assign clearAllowed = ~break_state | break_flag_clear_enable; // R22
    assign wrapClearOk = wrap_flag_clear & wrapArmed & clearAllowed; // R22
    assign ch0ClearOk = ch0_flag_clear & ch0Armed & clearAllowed; // R22
    assign ch1ClearOk = ch1_flag_clear & ch1Armed & clearAllowed; // R22

    // Flags: a new event wins over a clear in the same cycle.
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wrap_flag <= 1'b0;
            ch0_event_flag <= 1'b0;
            ch1_event_flag <= 1'b0;
            wrapArmed <= 1'b0;
            ch0Armed <= 1'b0;
            ch1Armed <= 1'b0;
        end
        else
        begin
            if (wrap)
            begin
                wrap_flag <= 1'b1; // R17
                wrapArmed <= 1'b0;
            end
            else if (wrapClearOk)
            begin
                wrap_flag <= 1'b0;
                wrapArmed <= 1'b0;
            end
            else if (wrap_flag_read & wrap_flag & clearAllowed)
            begin
                wrapArmed <= 1'b1;
            end
            // Channel 0 flag, fed by whichever compare pair governs the pin.
            if (match0)
            begin
                ch0_event_flag <= 1'b1; // R18
                ch0Armed <= 1'b0;
            end
            else if (ch0ClearOk)
            begin
                ch0_event_flag <= 1'b0;
                ch0Armed <= 1'b0;
            end
            else if (ch0_flag_read & ch0_event_flag & clearAllowed)
            begin
                ch0Armed <= 1'b1;
            end
            // Channel 1 flag; its match is already gated off while linked.
            if (match1)
            begin
                ch1_event_flag <= 1'b1; // R18 R9
                ch1Armed <= 1'b0;
            end
            else if (ch1ClearOk)
            begin
                ch1_event_flag <= 1'b0;
                ch1Armed <= 1'b0;
            end
            else if (ch1_flag_read & ch1_event_flag & clearAllowed)
            begin
                ch1Armed <= 1'b1;
            end
        end
    end

    // Request output also serves as the wake source in wait mode.
    // Channel 1 requests are dropped while linked, as its control is then unused.
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            timer_irq <= 1'b0;
        end
        else
        begin
            timer_irq <= (wrap_flag & wrap_irq_enable) | (ch0_event_flag & ch0_irq_enable)
                | (ch1_event_flag & ch1_irq_enable & ~linked); // R17 R18 R19
        end
    end

endmodule

// File: verification/tpwm_checker_sva.sv
// Concurrent checks on the ports of the PWM timer block.
`timescale 1ns/1ps
`include "tpwm_consts.vh"
module tpwm_checker_sva
(
    input wire clk_sys,
    input wire sys_rst,
    input wire counter_halt_bit,
    input wire counter_clear,
    input wire [2:0] prescale_select,
    input wire [15:0] modulo_value,
    input wire modulo_write,
    input wire [1:0] ch0_mode,
    input wire [1:0] ch0_output_action,
    input wire ch0_toggle_on_wrap_bit,
    input wire ch0_full_duty_bit,
    input wire wrap_irq_enable,
    input wire ch0_irq_enable,
    input wire ch1_irq_enable,
    input wire wrap_flag_clear,
    input wire stop_mode,
    input wire break_state,
    input wire break_flag_clear_enable,
    input wire [15:0] counter,
    input wire channel0_pin,
    input wire channel1_pin_released,
    input wire wrap_flag,
    input wire ch0_event_flag,
    input wire ch1_event_flag,
    input wire timer_irq
);
    reg [15:0] modShadow;
    reg [2:0] psPrev;
    wire irqCause = (wrap_flag && wrap_irq_enable) || (ch0_event_flag && ch0_irq_enable)
        || (ch1_event_flag && ch1_irq_enable && !ch0_mode[`TPWM_MS_B]);
    wire freeRun = !counter_halt_bit && !counter_clear && !stop_mode && !break_state && !modulo_write
        && prescale_select == 3'h0 && psPrev == 3'h0;
    // Shadow of the modulo register, so that wrap points can be predicted.
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            modShadow <= `TPWM_MOD_RESET;
            psPrev <= 3'h0;
        end
        else
        begin
            psPrev <= prescale_select;
            if (modulo_write)
                modShadow <= modulo_value;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence wrapStep;
        freeRun && counter == modShadow;
    endsequence
    sequence wrapDone;
        counter == 16'h0000 && wrap_flag;
    endsequence
    sequence fullOn;
        ch0_full_duty_bit && ch0_toggle_on_wrap_bit && ch0_output_action == `TPWM_ACT_CLEAR;
    endsequence
    sequence blockedClear;
        break_state && !break_flag_clear_enable && wrap_flag && wrap_flag_clear;
    endsequence
    count_step_a: assert property (freeRun && counter != modShadow |=> counter == $past(counter) + 16'h0001)
        else $error("counter did not step");
    wrap_restart_a: assert property (wrapStep |=> wrapDone)
        else $error("wrap missed");
    freeze_hold_a: assert property ((counter_halt_bit || stop_mode || break_state) && !counter_clear |=> $stable(counter))
        else $error("frozen counter moved");
    clear_zero_a: assert property (counter_clear |=> counter == 16'h0000)
        else $error("clear failed");
    irq_follow_a: assert property (timer_irq == $past(irqCause))
        else $error("request wrong");
    link_release_a: assert property ($rose(ch0_mode[`TPWM_MS_B]) |-> ##[1:2] channel1_pin_released)
        else $error("pin not released");
    zero_duty_a: assert property (ch0_output_action == `TPWM_ACT_CLEAR && !ch0_toggle_on_wrap_bit && !ch0_full_duty_bit
        |=> !$rose(channel0_pin))
        else $error("pin rose");
    full_duty_a: assert property (fullOn ##1 fullOn |-> channel0_pin)
        else $error("pin not high");
    break_guard_a: assert property (blockedClear |=> wrap_flag)
        else $error("flag cleared in break");
endmodule

// File: verification/tpwm_load_model.sv
// Load on the PWM pin that measures high time and period.
`timescale 1ns/1ps
module tpwm_load_model
(
    input wire clk_sys,
    input wire pwmPin,
    output reg [15:0] highTime,
    output reg [15:0] periodTime
);
    reg prevPin = 1'b0;
    reg [15:0] hiCnt = 16'h0000;
    reg [15:0] perCnt = 16'h0000;
    // Period runs rising edge to rising edge, high time rising edge to fall; the first period reported is the partial one counted from time zero.
    always @(posedge clk_sys)
    begin
        prevPin <= pwmPin;
        if (pwmPin && !prevPin)
        begin
            periodTime <= perCnt;
            perCnt <= 16'h0001;
            hiCnt <= 16'h0001;
        end
        else
        begin
            perCnt <= perCnt + 16'h0001;
            if (pwmPin)
                hiCnt <= hiCnt + 16'h0001;
            if (!pwmPin && prevPin)
                highTime <= hiCnt;
        end
    end
endmodule

// File: verification/tpwm_timer_pwm_channels_tb.sv
// Bench for the PWM timer block, driving its ports and judging pin timing.
`timescale 1ns/1ps
`include "tpwm_consts.vh"
module tpwm_timer_pwm_channels_tb;
    reg clk_sys = 1'b0;
    reg sys_rst = 1'b1;
    reg counter_halt_bit = 1'b1;
    reg counter_clear = 1'b0, modulo_write = 1'b0, compare0_write = 1'b0, compare1_write = 1'b0;
    reg [2:0] prescale_select = 3'h0;
    reg [15:0] modulo_value = 16'h0000, compare0_value = 16'h0000, compare1_value = 16'h0000, held;
    reg [1:0] ch0_mode = 2'h1, ch0_output_action = `TPWM_ACT_CLEAR;
    reg ch0_toggle_on_wrap_bit = 1'b1, ch0_full_duty_bit = 1'b0, wrap_irq_enable = 1'b0, ch0_irq_enable = 1'b0;
    reg wrap_flag_read = 1'b0, wrap_flag_clear = 1'b0, stop_mode = 1'b0, break_state = 1'b0;
    reg break_flag_clear_enable = 1'b0, ch1_irq_enable = 1'b0;
    wire [15:0] counter, highTime, periodTime;
    wire channel0_pin, channel1_pin, channel1_pin_released, active_pair, wrap_flag, ch0_event_flag;
    wire ch1_event_flag, timer_irq;
    integer fails = 0, n_tests = 0, cycles = 0;
    // Channel 1 shares the channel 0 pin settings, with its mode fixed at unbuffered compare, so that its logic runs too.
    tpwm_timer_pwm_channels dut_u (.clk_sys, .sys_rst, .counter_halt_bit, .counter_clear, .prescale_select,
        .modulo_value, .modulo_write, .compare0_value, .compare0_write, .compare1_value, .compare1_write,
        .ch0_mode, .ch1_mode(2'h1), .ch0_output_action, .ch1_output_action(ch0_output_action),
        .ch0_toggle_on_wrap_bit, .ch1_toggle_on_wrap_bit(ch0_toggle_on_wrap_bit), .ch0_full_duty_bit,
        .ch1_full_duty_bit(ch0_full_duty_bit), .wrap_irq_enable, .ch0_irq_enable, .ch1_irq_enable,
        .wrap_flag_read, .wrap_flag_clear, .ch0_flag_read(wrap_flag_read), .ch0_flag_clear(wrap_flag_clear),
        .ch1_flag_read(wrap_flag_read), .ch1_flag_clear(wrap_flag_clear), .stop_mode, .break_state,
        .break_flag_clear_enable, .counter, .channel0_pin, .channel1_pin, .channel1_pin_released,
        .active_pair, .wrap_flag, .ch0_event_flag, .ch1_event_flag, .timer_irq);
    tpwm_load_model load_u (.clk_sys, .pwmPin(channel0_pin), .highTime, .periodTime);
    initial forever #5 clk_sys = ~clk_sys;
    task cyc(input integer n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task check(input [15:0] seen, input [15:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task final_report;
        $display("fails=%0d n_tests=%0d", fails, n_tests);
        if (fails == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Halt and clear in the same edge as the writes, so the new modulo never meets a counter already past it.
    task setup(input [15:0] m, input [15:0] w);
        counter_halt_bit = 1'b1;
        counter_clear = 1'b1;
        modulo_value = m;
        modulo_write = 1'b1;
        compare0_value = w;
        compare0_write = 1'b1;
        cyc(1);
        counter_clear = 1'b0;
        modulo_write = 1'b0;
        compare0_write = 1'b0;
        check(counter, 16'h0000);
        counter_halt_bit = 1'b0;
    endtask
    task t_pwm;
        wrap_irq_enable = 1'b1;
        setup(16'h00FF, 16'h0080);
        cyc(800);
        check(periodTime, 16'h0100);
        check(highTime, 16'h0080);
        check(wrap_flag, 1'b1);
        check(ch0_event_flag, 1'b1);
        check(timer_irq, 1'b1);
        check(ch1_event_flag, 1'b1);
        check(channel1_pin, 1'b0);
        // Shorter width written just after the compare, longer one just after the wrap.
        @(negedge channel0_pin);
        #1;
        compare0_value = 16'h0040;
        compare0_write = 1'b1;
        cyc(1);
        compare0_write = 1'b0;
        cyc(600);
        check(highTime, 16'h0040);
        @(posedge channel0_pin);
        #1;
        compare0_value = 16'h0080;
        compare0_write = 1'b1;
        cyc(1);
        compare0_write = 1'b0;
        cyc(600);
        check(highTime, 16'h0080);
    endtask
    task t_level;
        setup(16'h003F, 16'h0020);
        ch0_toggle_on_wrap_bit = 1'b0;
        cyc(140);
        check(channel0_pin, 1'b0);
        ch0_toggle_on_wrap_bit = 1'b1;
        ch0_full_duty_bit = 1'b1;
        cyc(70);
        check(channel0_pin, 1'b1);
        ch0_full_duty_bit = 1'b0;
        wrap_irq_enable = 1'b0;
        cyc(2);
        check(timer_irq, 1'b0);
        ch0_irq_enable = 1'b1;
        cyc(2);
        check(timer_irq, 1'b1);
        ch0_irq_enable = 1'b0;
        ch1_irq_enable = 1'b1;
        cyc(2);
        check(timer_irq, 1'b1);
        ch1_irq_enable = 1'b0;
    endtask
    task t_scale;
        integer i;
        setup(16'h000F, 16'h0008);
        for (i = 0; i < 7; i = i + 1)
        begin
            prescale_select = i[2:0];
            cyc(64 << i);
            check(periodTime, 16'h0010 << i);
            check(highTime, 16'h0008 << i);
        end
        prescale_select = `TPWM_PS_UNUSED;
        held = counter;
        cyc(40);
        check(counter, held);
        prescale_select = 3'h0;
    endtask
    // A long modulo keeps new wraps away while the flag clear steps are tried.
    task t_freeze;
        setup(16'hFFFF, 16'h0080);
        wrap_flag_read = 1'b1;
        cyc(1);
        wrap_flag_read = 1'b0;
        stop_mode = 1'b1;
        held = counter;
        cyc(20);
        check(counter, held);
        stop_mode = 1'b0;
        break_state = 1'b1;
        wrap_flag_clear = 1'b1;
        cyc(1);
        wrap_flag_clear = 1'b0;
        check(wrap_flag, 1'b1);
        check(counter, held);
        counter_halt_bit = 1'b1;
        break_state = 1'b0;
        cyc(1);
        wrap_flag_clear = 1'b1;
        cyc(1);
        wrap_flag_clear = 1'b0;
        check(wrap_flag, 1'b0);
    endtask
    task t_buffer;
        setup(16'h00FF, 16'h0080);
        ch0_mode = 2'h3;
        compare1_value = 16'h0040;
        compare1_write = 1'b1;
        cyc(1);
        compare1_write = 1'b0;
        check(active_pair, 1'b0);
        check(channel1_pin_released, 1'b1);
        cyc(800);
        check(active_pair, 1'b1);
        check(highTime, 16'h0040);
        check(ch1_event_flag, 1'b0);
    endtask
    initial
    begin
        cyc(20);
        sys_rst = 1'b0;
        cyc(1);
        t_pwm;
        t_level;
        t_scale;
        t_freeze;
        t_buffer;
        final_report;
    end
    // A hang counts as a mismatch and ends the run through the report.
    always @(posedge clk_sys)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            fails = fails + 1;
            final_report;
        end
    end
endmodule
bind tpwm_timer_pwm_channels tpwm_checker_sva chk_u (.clk_sys, .sys_rst, .counter_halt_bit, .counter_clear,
    .prescale_select, .modulo_value, .modulo_write, .ch0_mode, .ch0_output_action, .ch0_toggle_on_wrap_bit,
    .ch0_full_duty_bit, .wrap_irq_enable, .ch0_irq_enable, .ch1_irq_enable, .wrap_flag_clear, .stop_mode,
    .break_state, .break_flag_clear_enable, .counter, .channel0_pin, .channel1_pin_released, .wrap_flag,
    .ch0_event_flag, .ch1_event_flag, .timer_irq);
